// >>> logic/dcw_regs.vh
// Purpose: Shared constants of the converter housekeeping block
// Assumes: 24-bit command word, optional 8-bit check byte
// Notes:   Definitions only
`ifndef DCW_REGS_VH
`define DCW_REGS_VH

// Frame layout
`define DCW_WORD_BITS       24
`define DCW_FRAME_BITS      32
`define DCW_CMD_MSB         23
`define DCW_CMD_LSB         21
`define DCW_CH_MSB          17
`define DCW_CH_LSB          16

// Command codes in bits 23:21
`define DCW_CMD_DATA        3'h0
`define DCW_CMD_GAIN        3'h1
`define DCW_CMD_OFFSET      3'h2
`define DCW_CMD_CLRCODE     3'h3
`define DCW_CMD_DACCTL      3'h4
`define DCW_CMD_MAINCTL     3'h5
`define DCW_CMD_SOFT        3'h6
`define DCW_CMD_READ        3'h7

// Readback selectors (data bits 3:0)
`define DCW_RD_STATUS       4'h0
`define DCW_RD_MAINCTL      4'h1
`define DCW_RD_GAIN         2'h1
`define DCW_RD_OFFSET       2'h2
`define DCW_RD_CLRCODE      2'h3

// Main control fields
`define DCW_MC_SOW_BIT      0
`define DCW_MC_WDEN_BIT     1
`define DCW_MC_TSEL_LSB     2
`define DCW_MC_WIDTH        4
// Dac control field
`define DCW_DC_CLRALLOW_BIT 0
// Software register
`define DCW_SOFT_KEY        12'h195
`define DCW_SOFT_TOGGLE_BIT 12

// Status word fields
`define DCW_ST_OTEMP_BIT    8
`define DCW_ST_FCERR_BIT    10
`define DCW_ST_TOGGLE_BIT   11

// Reset values
`define DCW_GAIN_RST        12'hfff
`define DCW_OFFSET_RST      12'h800
`define DCW_CLRCODE_RST     12'h000
`define DCW_CODE_RST        12'h000
`define DCW_MAINCTL_RST     4'h0

// Calibration
`define DCW_CAL_SHIFT       12
`define DCW_CAL_MID         14'sh0800
`define DCW_CODE_MAX        12'hfff

// Check byte polynomial x^8+x^2+x+1
`define DCW_CRC_POLY        8'h07

// Timing
`define DCW_CLK_KHZ         200000
`define DCW_WD_T0_MS        5
`define DCW_WD_T1_MS        10
`define DCW_WD_T2_MS        100
`define DCW_WD_T3_MS        200

`endif

// >>> logic/dcw_cal.v
// Purpose: Shared gain and offset trim engine, one multiplier and one adder
// Assumes: One request at a time; start ignored while busy
// Notes:   Result two cycles after start, clamped to the code range
`include "dcw_regs.vh"

module dcw_cal #(
  parameter W = 12
) (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         rst_in,
  // Request
  input  wire         start_in,
  input  wire [1:0]   chan_in,
  input  wire [W-1:0] data_in,
  input  wire [W-1:0] gain_in,
  input  wire [W-1:0] offset_in,
  // Answer
  output wire         busy_out,
  output reg          done_out,
  output reg  [1:0]   chan_out,
  output reg  [W-1:0] code_out
);

  reg  [2*W:0]   prod_q;
  reg  [W-1:0]   off_q;
  reg            stage_q;
  wire [W:0]     scaled;
  wire signed [W+2:0] sum;

  assign busy_out = stage_q | done_out;
  assign scaled   = prod_q[2*W:`DCW_CAL_SHIFT];
  // Signed so that a small offset can go below zero before clamping
  assign sum = $signed({2'b00, scaled}) + $signed({3'b000, off_q}) - `DCW_CAL_MID;

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prod_q   <= {(2*W+1){1'b0}};
      off_q    <= {W{1'b0}};
      stage_q  <= 1'b0;
      done_out <= 1'b0;
      chan_out <= 2'h0;
      code_out <= {W{1'b0}};
    end
    else
    begin
      done_out <= stage_q;
      stage_q  <= 1'b0;
      if (start_in && !busy_out)
      begin
        prod_q   <= data_in * ({1'b0, gain_in} + {{W{1'b0}}, 1'b1});
        off_q    <= offset_in;
        chan_out <= chan_in;
        stage_q  <= 1'b1;
      end
      if (stage_q)
      begin
        if (sum < 0)
          code_out <= {W{1'b0}};
        else if (sum > $signed({3'b000, `DCW_CODE_MAX}))
          code_out <= `DCW_CODE_MAX;
        else
          code_out <= sum[W-1:0];
      end
    end
  end

endmodule

// >>> logic/dcw_top.v
// Purpose: Fault alarm, trim, clear, frame check and watchdog of a 4-channel converter
// Assumes: Serial pins asynchronous to clk_sys_in; sclk well below clk_sys_in / 4
// Notes:   Input sampled on sclk falling edge, serial_out moves on rising edge
`include "dcw_regs.vh"

module dcw_top #(
  parameter W       = 12,
  parameter CH      = 4,
  parameter WD_CYC0 = `DCW_WD_T0_MS * `DCW_CLK_KHZ,
  parameter WD_CYC1 = `DCW_WD_T1_MS * `DCW_CLK_KHZ,
  parameter WD_CYC2 = `DCW_WD_T2_MS * `DCW_CLK_KHZ,
  parameter WD_CYC3 = `DCW_WD_T3_MS * `DCW_CLK_KHZ
) (
  // Clock and reset
  input  wire            clk_sys_in,
  input  wire            rst_in,
  // Serial link
  input  wire            sclk_in,
  input  wire            sync_n_in,
  input  wire            serial_in,
  output reg             serial_out,
  // Fault sources
  input  wire [CH-1:0]   out_fault_in,
  input  wire            overtemp_in,
  // Alarm, open drain
  output wire            alarm_n_out,
  output wire            alarm_oe_out,
  // Clear and watchdog
  input  wire            clear_in,
  output reg             alert_out,
  // Channel codes, channel 0 in the low bits
  output wire [CH*W-1:0] dac_code_out
);

  function [7:0] crc_step;
    input [7:0] crc;
    input       din;
    begin
      crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? `DCW_CRC_POLY : 8'h00);
    end
  endfunction

  function [25:0] wd_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    wd_limit = WD_CYC0[25:0];
        2'h1:    wd_limit = WD_CYC1[25:0];
        2'h2:    wd_limit = WD_CYC2[25:0];
        default: wd_limit = WD_CYC3[25:0];
      endcase
    end
  endfunction

  // Synchronisers: stage 1 read only by stage 2
  reg [1:0]      sclk_s_q, sync_s_q, sdi_s_q, clr_s_q, ot_s_q;
  reg [2*CH-1:0] flt_s_q;
  reg            sclk_d_q, sync_d_q, clr_d_q;

  // Channel state
  reg [W-1:0]  gain_q    [0:CH-1];
  reg [W-1:0]  offset_q  [0:CH-1];
  reg [W-1:0]  clrcode_q [0:CH-1];
  reg [W-1:0]  data_q    [0:CH-1];
  reg [W-1:0]  code_q    [0:CH-1];
  reg [CH-1:0] clear_allow_q;
  reg [CH-1:0] pend_q;

  // Control and status
  reg [`DCW_MC_WIDTH-1:0] mainctl_q;
  reg          fc_err_q;
  reg          toggle_q;

  // Frame receiver
  reg [31:0]   shin_q;
  reg [5:0]    cnt_q;
  reg [7:0]    crc_q;
  reg [15:0]   shout_q;
  reg [15:0]   rb_word_q;
  reg          rb_status_q;
  reg          out_status_q;

  // Watchdog
  reg [25:0]   wd_cnt_q;

  wire sclk_rise  = sclk_s_q[1] & ~sclk_d_q;
  wire sclk_fall  = ~sclk_s_q[1] & sclk_d_q;
  wire sync_fall  = ~sync_s_q[1] & sync_d_q;
  wire sync_rise  = sync_s_q[1] & ~sync_d_q;
  wire clr_rise   = clr_s_q[1] & ~clr_d_q;
  wire in_frame   = ~sync_s_q[1];
  wire [CH-1:0] flt_now = flt_s_q[2*CH-1:CH];
  wire sow_en     = mainctl_q[`DCW_MC_SOW_BIT];
  wire wd_en      = mainctl_q[`DCW_MC_WDEN_BIT];
  wire [1:0] tsel = mainctl_q[`DCW_MC_TSEL_LSB+1:`DCW_MC_TSEL_LSB];

  wire len24   = (cnt_q == `DCW_WORD_BITS);
  wire len32   = (cnt_q == `DCW_FRAME_BITS);
  wire crc_ok  = (shin_q[7:0] == crc_q);
  wire [23:0] word = len32 ? shin_q[31:8] : shin_q[23:0];
  wire frame_ok  = sync_rise & (len24 | (len32 & crc_ok));
  wire frame_bad = sync_rise & len32 & ~crc_ok;
  wire [2:0] cmd = word[`DCW_CMD_MSB:`DCW_CMD_LSB];
  wire [1:0] wch = word[`DCW_CH_MSB:`DCW_CH_LSB];
  wire [W-1:0] wval = word[W-1:0];
  wire key_ok = frame_ok & (cmd == `DCW_CMD_SOFT) & (wval == `DCW_SOFT_KEY);

  wire [15:0] status_word;
  assign status_word = {4'h0, toggle_q, fc_err_q, 1'b0, ot_s_q[1], 4'h0, flt_now};

  // Wired-OR fault line: pull low or release
  wire alarm_act = (|flt_now) | ot_s_q[1] | fc_err_q;
  assign alarm_n_out  = 1'b0;
  assign alarm_oe_out = alarm_act;

  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1)
    begin : g_out
      assign dac_code_out[g*W +: W] = code_q[g];
    end
  endgenerate

  // Shared calibration arbiter, lowest pending channel first
  reg  [1:0] pick;
  integer    k;
  always @*
  begin
    pick = 2'h0;
    for (k = CH-1; k >= 0; k = k - 1)
      if (pend_q[k])
        pick = k[1:0];
  end

  wire         cal_busy;
  wire         cal_done;
  wire [1:0]   cal_ch;
  wire [W-1:0] cal_code;
  wire         cal_go = (|pend_q) & ~cal_busy;

  dcw_cal #(
    .W (W)
  ) u_cal (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .start_in   (cal_go),
    .chan_in    (pick),
    .data_in    (data_q[pick]),
    .gain_in    (gain_q[pick]),
    .offset_in  (offset_q[pick]),
    .busy_out   (cal_busy),
    .done_out   (cal_done),
    .chan_out   (cal_ch),
    .code_out   (cal_code)
  );

  // Readback word for a read command
  reg [15:0] rb_sel_word;
  always @*
  begin
    case (wval[3:2])
      `DCW_RD_GAIN:    rb_sel_word = {4'h0, gain_q[wval[1:0]]};
      `DCW_RD_OFFSET:  rb_sel_word = {4'h0, offset_q[wval[1:0]]};
      `DCW_RD_CLRCODE: rb_sel_word = {4'h0, clrcode_q[wval[1:0]]};
      default:
        rb_sel_word = (wval[3:0] == `DCW_RD_MAINCTL) ? {12'h000, mainctl_q} : status_word;
    endcase
  end

  integer i;
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Link clock idles high, so reset to that level: no false edge after reset
      sclk_s_q <= 2'b11;
      sync_s_q <= 2'b11;
      sdi_s_q  <= 2'b00;
      clr_s_q  <= 2'b00;
      ot_s_q   <= 2'b00;
      flt_s_q  <= {2*CH{1'b0}};
      sclk_d_q <= 1'b1;
      sync_d_q <= 1'b1;
      clr_d_q  <= 1'b0;
      for (i = 0; i < CH; i = i + 1)
      begin
        gain_q[i]    <= `DCW_GAIN_RST;
        offset_q[i]  <= `DCW_OFFSET_RST;
        clrcode_q[i] <= `DCW_CLRCODE_RST;
        data_q[i]    <= {W{1'b0}};
        code_q[i]    <= `DCW_CODE_RST;
      end
      clear_allow_q <= {CH{1'b0}};
      pend_q       <= {CH{1'b0}};
      mainctl_q    <= `DCW_MAINCTL_RST;
      fc_err_q     <= 1'b0;
      toggle_q     <= 1'b0;
      shin_q       <= 32'h0000_0000;
      cnt_q        <= 6'h00;
      crc_q        <= 8'h00;
      shout_q      <= 16'h0000;
      rb_word_q    <= 16'h0000;
      rb_status_q  <= 1'b0;
      out_status_q <= 1'b0;
      serial_out   <= 1'b0;
      wd_cnt_q     <= 26'h000_0000;
      alert_out    <= 1'b0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], sclk_in};
      sync_s_q <= {sync_s_q[0], sync_n_in};
      sdi_s_q  <= {sdi_s_q[0], serial_in};
      clr_s_q  <= {clr_s_q[0], clear_in};
      ot_s_q   <= {ot_s_q[0], overtemp_in};
      flt_s_q  <= {flt_s_q[CH-1:0], out_fault_in};
      sclk_d_q <= sclk_s_q[1];
      sync_d_q <= sync_s_q[1];
      clr_d_q  <= clr_s_q[1];

      // Frame start: pick what goes out on serial_out
      if (sync_fall)
      begin
        cnt_q <= 6'h00;
        crc_q <= 8'h00;
        out_status_q <= sow_en | rb_status_q;
        if (sow_en)
        begin
          shout_q    <= {status_word[14:0], 1'b0};
          serial_out <= status_word[15];
        end
        else
        begin
          shout_q    <= {rb_word_q[14:0], 1'b0};
          serial_out <= rb_word_q[15];
        end
      end
      else if (in_frame && sclk_rise)
      begin
        serial_out <= shout_q[15];
        shout_q    <= {shout_q[14:0], 1'b0};
      end
      else if (!in_frame)
        serial_out <= 1'b0;

      if (in_frame && sclk_fall)
      begin
        shin_q <= {shin_q[30:0], sdi_s_q[1]};
        if (cnt_q != 6'h3f)
          cnt_q <= cnt_q + 6'h01;
        if (cnt_q < `DCW_WORD_BITS)
          crc_q <= crc_step(crc_q, sdi_s_q[1]);
      end

      // Register writes at frame end
      if (frame_ok)
      begin
        rb_status_q <= 1'b0;
        case (cmd)
          `DCW_CMD_DATA:
          begin
            data_q[wch] <= wval;
            pend_q[wch] <= 1'b1;
          end
          `DCW_CMD_GAIN:    gain_q[wch] <= wval;
          `DCW_CMD_OFFSET:  offset_q[wch] <= wval;
          `DCW_CMD_CLRCODE: clrcode_q[wch] <= wval;
          `DCW_CMD_DACCTL:  clear_allow_q[wch] <= wval[`DCW_DC_CLRALLOW_BIT];
          `DCW_CMD_MAINCTL: mainctl_q <= wval[`DCW_MC_WIDTH-1:0];
          `DCW_CMD_SOFT:    toggle_q <= word[`DCW_SOFT_TOGGLE_BIT];
          `DCW_CMD_READ:
          begin
            // Status-on-write owns serial_out, so other reads are dropped
            if (!sow_en)
            begin
              rb_word_q   <= rb_sel_word;
              rb_status_q <= (rb_sel_word == status_word) &&
                             (wval[3:2] == 2'h0) && (wval[3:0] != `DCW_RD_MAINCTL);
            end
          end
          default: ;
        endcase
      end

      // Shared engine: take the request, then store the result
      if (cal_go)
        pend_q[pick] <= 1'b0;
      if (frame_ok && cmd == `DCW_CMD_DATA && cal_go && pick == wch)
        pend_q[wch] <= 1'b1;
      if (cal_done)
        code_q[cal_ch] <= cal_code;

      // Clear edge wins over a result landing the same cycle
      if (clr_rise)
      begin
        for (i = 0; i < CH; i = i + 1)
          if (clear_allow_q[i])
            code_q[i] <= clrcode_q[i];
      end

      // Error flag: read of status clears, a new failure wins
      if (sync_rise && out_status_q && (len24 || len32))
        fc_err_q <= 1'b0;
      if (frame_bad)
        fc_err_q <= 1'b1;

      // Watchdog
      if (!wd_en || key_ok)
      begin
        wd_cnt_q  <= 26'h000_0000;
        alert_out <= 1'b0;
      end
      else if (wd_cnt_q >= wd_limit(tsel) - 26'h000_0001)
        alert_out <= 1'b1;
      else
        wd_cnt_q <= wd_cnt_q + 26'h000_0001;
    end
  end

endmodule

// >>> testbench/dcw_top_sva.sv
// Purpose: Port-level assertions for dcw_top
// Assumes: Serial pins and fault inputs asynchronous to clk_sys_in
// Notes:   Helper counters saturate, so long idle spans stay harmless
module dcw_top_sva #(
  parameter int W       = 12,
  parameter int CH      = 4,
  parameter int WD_CYC0 = 1000000
) (
  // Clock and reset
  input wire logic            clk_sys_in,
  input wire logic            rst_in,
  // Serial link
  input wire logic            sclk_in,
  input wire logic            sync_n_in,
  input wire logic            serial_in,
  input wire logic            serial_out,
  // Faults, alarm, clear, alert
  input wire logic [CH-1:0]   out_fault_in,
  input wire logic            overtemp_in,
  input wire logic            alarm_n_out,
  input wire logic            alarm_oe_out,
  input wire logic            clear_in,
  input wire logic            alert_out,
  input wire logic [CH*W-1:0] dac_code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] idle_q;
  logic [7:0]  quiet_q;
  logic [7:0]  evt_q;
  logic        sync_q;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      idle_q  <= 32'h0;
      quiet_q <= 8'h00;
      evt_q   <= 8'h00;
      sync_q  <= 1'b1;
    end
    else
    begin
      idle_q  <= !sync_n_in ? 32'h0 : idle_q + {31'h0, ~&idle_q};
      quiet_q <= (!sync_n_in || clear_in) ? 8'h00 : quiet_q + {7'h0, ~&quiet_q};
      // Any alarm cause restarts the age count
      evt_q   <= (|out_fault_in || overtemp_in || (sync_n_in && !sync_q)) ? 8'h00
                 : evt_q + {7'h0, ~&evt_q};
      sync_q  <= sync_n_in;
    end
  end

  alarm_drive_a: assert property (alarm_n_out == 1'b0)
    else $error("alarm data not low");
  fault_alarm_a: assert property ((|out_fault_in) [*5] |-> alarm_oe_out)
    else $error("output fault did not raise alarm");
  overtemp_alarm_a: assert property (overtemp_in [*5] |-> alarm_oe_out)
    else $error("overtemperature did not raise alarm");
  alarm_cause_a: assert property ($rose(alarm_oe_out) |-> evt_q < 8'd12)
    else $error("alarm rose without a cause");
  alert_wait_a: assert property ($rose(alert_out) |-> idle_q > WD_CYC0 / 2)
    else $error("alert rose while the link was busy");
  code_hold_a: assert property (quiet_q > 8'd20 |-> $stable(dac_code_out))
    else $error("code changed without write or clear");
  serial_idle_a: assert property (sync_n_in [*8] |-> !serial_out)
    else $error("serial output not low outside frame");
  serial_steady_a: assert property ((!sync_n_in && !sclk_in) [*6] |-> $stable(serial_out))
    else $error("serial output moved while clock low");

  crc_fail_c: cover property ($rose(alarm_oe_out) && sync_n_in);
  alert_c: cover property ($rose(alert_out));
  clear_c: cover property ($rose(clear_in));
endmodule

bind dcw_top dcw_top_sva #(.W(W), .CH(CH), .WD_CYC0(WD_CYC0)) chk_u (
  .clk_sys_in, .rst_in, .sclk_in, .sync_n_in, .serial_in, .serial_out,
  .out_fault_in, .overtemp_in, .alarm_n_out, .alarm_oe_out, .clear_in,
  .alert_out, .dac_code_out
);

// >>> testbench/dcw_host.sv
// Purpose: Serial host model driving frames into dcw_top
// Assumes: 80 ns link clock, idle high, data taken on falling edge
// Notes:   Link clock stands still between frames
module dcw_host (
  // System clock for pacing
  input  wire logic clk_sys_in,
  // Link
  input  wire logic dev_data_in,
  output logic      sclk_out,
  output logic      sync_n_out,
  output logic      host_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;

  initial
  begin
    sclk_out      = 1'b1;
    sync_n_out    = 1'b1;
    host_data_out = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Only the 24 word bits are returned; check bytes are dropped
  task automatic frame(input logic [23:0] w, input logic chk, input logic bad,
                       output logic [23:0] rx);
    logic [31:0] f;
    int          n;
    f = {w, crc8(w) ^ {7'h00, bad}};
    n = chk ? 32 : 24;
    @(posedge clk_sys_in);
    sync_n_out <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sclk_out      <= 1'b1;
      host_data_out <= f[31-i];
      repeat (HALF) @(posedge clk_sys_in);
      if (i < 24)
        rx[23-i] = dev_data_in;
      sclk_out <= 1'b0;
      repeat (HALF) @(posedge clk_sys_in);
    end
    sclk_out      <= 1'b1;
    // Released line shows the inverse of its last bit
    host_data_out <= ~f[32-n];
    repeat (HALF) @(posedge clk_sys_in);
    sync_n_out <= 1'b1;
    repeat (24) @(posedge clk_sys_in);
  endtask
endmodule

// >>> testbench/dcw_top_bench.sv
// Purpose: Self-checking bench for dcw_top
// Assumes: Watchdog limits shrunk to keep the run short
// Notes:   Scenarios run in order; later ones rely on earlier codes
`include "dcw_regs.vh"
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module dcw_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD0 = 2000;
  logic        clk_sys_in;
  logic        rst_in;
  logic        sclk;
  logic        sync_n;
  logic        sdi;
  logic        dev_out;
  logic [3:0]  out_fault;
  logic        overtemp;
  logic        alarm_n;
  logic        alarm_oe;
  logic        clear;
  logic        alert;
  logic [47:0] codes;
  logic [23:0] rx;
  int          bad_count = 0;
  int          n_tests = 0;

  dcw_top #(.WD_CYC0(WD0), .WD_CYC1(2*WD0), .WD_CYC2(3*WD0), .WD_CYC3(4*WD0)) dut_u (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .sclk_in      (sclk),
    .sync_n_in    (sync_n),
    .serial_in    (sdi),
    .serial_out   (dev_out),
    .out_fault_in (out_fault),
    .overtemp_in  (overtemp),
    .alarm_n_out  (alarm_n),
    .alarm_oe_out (alarm_oe),
    .clear_in     (clear),
    .alert_out    (alert),
    .dac_code_out (codes)
  );
  dcw_host host_u (.clk_sys_in(clk_sys_in), .dev_data_in(dev_out), .sclk_out(sclk),
                   .sync_n_out(sync_n), .host_data_out(sdi));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [2:0] cmd, input logic [1:0] ch, input logic [11:0] v,
                    input logic chk = 1'b0, input logic bad = 1'b0);
    host_u.frame({cmd, 3'h0, ch, 4'h0, v}, chk, bad, rx);
  endtask

  function automatic logic [11:0] code(input int ch);
    return codes[ch*12 +: 12];
  endfunction

  // Status comes out on the frame after the read request, in its first 16 bits
  task automatic status(output logic [15:0] s);
    wr(`DCW_CMD_READ, 2'h0, 12'h000);
    wr(`DCW_CMD_READ, 2'h0, 12'h000);
    s = rx[23:8];
  endtask

  task automatic wait_alert(input int n);
    while (alert !== 1'b1 && n > 0)
    begin
      tick(1);
      n--;
    end
    if (alert !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic t_basic();
    `CHK({codes, alarm_n, alarm_oe, alert}, 51'h0)
    wr(`DCW_CMD_DATA, 2'h0, 12'h123);
    `CHK(code(0), 12'h123)
    wr(`DCW_CMD_GAIN, 2'h1, 12'h7ff);
    wr(`DCW_CMD_OFFSET, 2'h1, 12'h900);
    `CHK(code(1), 12'h000)
    wr(`DCW_CMD_DATA, 2'h1, 12'h400);
    `CHK(code(1), 12'h300)
    wr(`DCW_CMD_DATA, 2'h2, 12'hfff);
    wr(`DCW_CMD_DATA, 2'h3, 12'h010);
    `CHK({code(3), code(2), code(1)}, 36'h010fff300)
  endtask

  task automatic t_crc();
    logic [15:0] s;
    wr(`DCW_CMD_DATA, 2'h2, 12'h055, 1'b1);
    `CHK(code(2), 12'h055)
    wr(`DCW_CMD_DATA, 2'h2, 12'h0aa, 1'b1, 1'b1);
    `CHK({code(2), alarm_oe}, {12'h055, 1'b1})
    status(s);
    `CHK(s, 16'h0400)
    `CHK(alarm_oe, 1'b0)
  endtask

  task automatic t_faults();
    logic [15:0] s;
    out_fault <= 4'h4;
    tick(6);
    `CHK(alarm_oe, 1'b1)
    status(s);
    `CHK(s, 16'h0004)
    out_fault <= 4'h0;
    overtemp  <= 1'b1;
    status(s);
    `CHK({s, alarm_oe}, {16'h0100, 1'b1})
    overtemp <= 1'b0;
    tick(6);
    `CHK(alarm_oe, 1'b0)
  endtask

  task automatic t_sow();
    wr(`DCW_CMD_MAINCTL, 2'h0, 12'h001);
    out_fault <= 4'h2;
    tick(6);
    // Main control read is refused while status rides on writes
    wr(`DCW_CMD_READ, 2'h0, 12'h001);
    wr(`DCW_CMD_DATA, 2'h3, 12'h020);
    `CHK({rx[23:8], code(3)}, {16'h0002, 12'h020})
    out_fault <= 4'h0;
    wr(`DCW_CMD_MAINCTL, 2'h0, 12'h000);
    // Still the word of the last status read: the refused request left no trace
    wr(`DCW_CMD_READ, 2'h0, 12'h001);
    `CHK(rx[23:8], 16'h0100)
    wr(`DCW_CMD_READ, 2'h0, 12'h000);
    `CHK(rx[23:8], 16'h0000)
  endtask

  task automatic t_rdback();
    logic [15:0] s;
    // Software register write with the toggle bit set, not the key
    host_u.frame(24'hc01000, 1'b0, 1'b0, rx);
    status(s);
    `CHK(s, 16'h0800)
    wr(`DCW_CMD_READ, 2'h0, 12'h005);
    wr(`DCW_CMD_READ, 2'h0, 12'h009);
    `CHK(rx[23:8], 16'h07ff)
    wr(`DCW_CMD_READ, 2'h0, 12'h000);
    `CHK(rx[23:8], 16'h0900)
  endtask

  task automatic t_clear();
    wr(`DCW_CMD_DACCTL, 2'h0, 12'h001);
    wr(`DCW_CMD_CLRCODE, 2'h0, 12'habc);
    clear <= 1'b1;
    tick(8);
    `CHK({code(1), code(0)}, 24'h300abc)
    clear <= 1'b0;
    tick(8);
    `CHK(code(0), 12'habc)
    wr(`DCW_CMD_DATA, 2'h0, 12'h001);
    `CHK(code(0), 12'h001)
    wr(`DCW_CMD_DACCTL, 2'h0, 12'h000);
    clear <= 1'b1;
    tick(8);
    `CHK(code(0), 12'h001)
    clear <= 1'b0;
  endtask

  task automatic t_wd();
    for (int t = 0; t < 4; t++)
    begin
      wr(`DCW_CMD_MAINCTL, 2'h0, 12'(t * 4 + 2));
      wr(`DCW_CMD_SOFT, 2'h0, `DCW_SOFT_KEY);
      tick(WD0 * (t + 1) - 100);
      `CHK(alert, 1'b0)
      wait_alert(400);
      `CHK(alert, 1'b1)
      wr(`DCW_CMD_SOFT, 2'h0, `DCW_SOFT_KEY);
      `CHK(alert, 1'b0)
    end
    wr(`DCW_CMD_MAINCTL, 2'h0, 12'h000);
  endtask

  initial
  begin
    rst_in    = 1'b1;
    out_fault = 4'h0;
    overtemp  = 1'b0;
    clear     = 1'b0;
    tick(2);
    rst_in <= 1'b0;
    tick(4);
    t_basic();
    t_crc();
    t_faults();
    t_sow();
    t_rdback();
    t_clear();
    t_wd();
    stop_test();
  end
endmodule
